// File: rtl/memory_traffic_router.sv
//----------------------------------------------------------------------
// Memory traffic router
//----------------------------------------------------------------------
// Purpose: Routes host accesses to internal SRAM, SDRAM and slow memory
// Assumes: Memory read data is synchronous to core_clk
// Notes: Hosts 0 MPU, 1 DSP, 2..5 DMA buses, 6 local bus
// Operation
// - All hosts single 8/16/32; bursts 32 only.
// - DMA display channel may burst at 16.
// - Size adaptation onto each memory width.
// - Every host reaches all three memories.
// - Four independent 32-bit DMA buses, concurrent when on different memories.
// - Internal port serves 192K byte SRAM.
// - Dedicated DSP bus port beside MPU.
// - Wait states stretch slow memory accesses.
// - Chip selects and strobes for external memories.
`timescale 1ns/1ps
module memory_traffic_router
    import mtr_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NH-1:0] h_req,
    input wire logic [NH-1:0] h_we,
    input wire logic [NH-1:0][1:0] h_size,
    input wire logic [NH-1:0][LEN_W-1:0] h_len,
    input wire logic [NH-1:0][31:0] h_addr,
    input wire logic [NH-1:0][31:0] h_wdata,
    input wire logic [NDMA-1:0] dma_lcd,
    output logic [NH-1:0] h_ack,
    output logic [NH-1:0] h_err,
    output logic [NH-1:0][31:0] h_rdata,
    output logic sram_en,
    output logic sram_we,
    output logic [15:0] sram_addr,
    output logic [3:0] sram_be,
    output logic [31:0] sram_wdata,
    input wire logic [31:0] sram_rdata,
    output logic sdram_cs_n,
    output logic sdram_oe_n,
    output logic sdram_we_n,
    output logic [24:0] sdram_addr,
    output logic [1:0] sdram_be_n,
    output logic [15:0] sdram_wdata,
    input wire logic [15:0] sdram_rdata,
    output logic [3:0] slow_cs_n,
    output logic slow_oe_n,
    output logic slow_we_n,
    output logic [23:0] slow_addr,
    output logic [1:0] slow_be_n,
    output logic [15:0] slow_wdata,
    input wire logic [15:0] slow_rdata
);

    logic [NH-1:0] tgt_sram, tgt_sdram, tgt_slow, legal, lcd_vec, err_ff;
    logic [NH-1:0] ack_sram, ack_sdram, ack_slow;
    logic [31:0] rd_sram, rd_sdram, rd_slow, sram_m_addr, sd_m_addr, sl_m_addr;
    logic sd_en, sd_we, sl_en, sl_we;
    logic [1:0] sd_be, sl_be;

    //------------------------------------------------------------------
    // Request decode
    //------------------------------------------------------------------
    // Display channel flag placed at the DMA host positions
    assign lcd_vec = {1'b0, dma_lcd, 2'b00};

    // Target decode and legality per host
    always_comb
    begin
        for (int i = 0; i < NH; i++)
        begin
            tgt_slow[i] = (h_addr[i][31:28] == SLOW_TAG) && !h_addr[i][SLOW_HOLE_BIT];
            tgt_sdram[i] = (h_addr[i][31:26] == SDRAM_TAG);
            tgt_sram[i] = (h_addr[i] >= SRAM_BASE) && (h_addr[i] < SRAM_END);
            legal[i] = (tgt_slow[i] || tgt_sdram[i] || tgt_sram[i]) && (h_size[i] != 2'h3);
            // Misaligned accesses are refused
            if ((h_size[i] == SZ_16 && h_addr[i][0]) || (h_size[i] == SZ_32 && h_addr[i][1:0] != 2'h0))
                legal[i] = 1'b0;
            // Bursts at 32 bits, or 16 bits for the display channel
            if (h_len[i] != '0 && h_size[i] != SZ_32 && !(h_size[i] == SZ_16 && lcd_vec[i]))
                legal[i] = 1'b0;
        end
    end

    // One-cycle refusal pulse for an illegal request
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            err_ff <= '0;
        else
            err_ff <= h_req & ~legal & ~err_ff;
    end

    //------------------------------------------------------------------
    // Memory ports
    //------------------------------------------------------------------
    // Internal SRAM, one full-width cycle per access
    mtr_mem_port #(.DW(SRAM_DW), .WAIT(SRAM_WAIT)) u_sram (
        .core_clk(core_clk),
        .rst(rst),
        .req(h_req & legal & tgt_sram),
        .we(h_we),
        .size(h_size),
        .len(h_len),
        .addr(h_addr),
        .wdata(h_wdata),
        .ack(ack_sram),
        .rdata(rd_sram),
        .m_en(sram_en),
        .m_we(sram_we),
        .m_addr(sram_m_addr),
        .m_be(sram_be),
        .m_wdata(sram_wdata),
        .m_rdata(sram_rdata)
    );

    // External SDRAM, half-word wide
    mtr_mem_port #(.DW(SDRAM_DW), .WAIT(SDRAM_WAIT)) u_sdram (
        .core_clk(core_clk),
        .rst(rst),
        .req(h_req & legal & tgt_sdram),
        .we(h_we),
        .size(h_size),
        .len(h_len),
        .addr(h_addr),
        .wdata(h_wdata),
        .ack(ack_sdram),
        .rdata(rd_sdram),
        .m_en(sd_en),
        .m_we(sd_we),
        .m_addr(sd_m_addr),
        .m_be(sd_be),
        .m_wdata(sdram_wdata),
        .m_rdata(sdram_rdata)
    );

    // Slow external memory, half-word wide with long wait
    mtr_mem_port #(.DW(SLOW_DW), .WAIT(SLOW_WAIT)) u_slow (
        .core_clk(core_clk),
        .rst(rst),
        .req(h_req & legal & tgt_slow),
        .we(h_we),
        .size(h_size),
        .len(h_len),
        .addr(h_addr),
        .wdata(h_wdata),
        .ack(ack_slow),
        .rdata(rd_slow),
        .m_en(sl_en),
        .m_we(sl_we),
        .m_addr(sl_m_addr),
        .m_be(sl_be),
        .m_wdata(slow_wdata),
        .m_rdata(slow_rdata)
    );

    //------------------------------------------------------------------
    // Memory control signals
    //------------------------------------------------------------------
    // Word and half-word addresses
    assign sram_addr = sram_m_addr[17:2];
    assign sdram_addr = sd_m_addr[25:1];
    assign slow_addr = sl_m_addr[24:1];

    // SDRAM select and strobes
    assign sdram_cs_n = !sd_en;
    assign sdram_oe_n = !(sd_en && !sd_we);
    assign sdram_we_n = !(sd_en && sd_we);
    assign sdram_be_n = ~sd_be;

    // Slow memory chip select from the address region
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            slow_cs_n[k] = !(sl_en && sl_m_addr[27:26] == 2'(k));
    end
    assign slow_oe_n = !(sl_en && !sl_we);
    assign slow_we_n = !(sl_en && sl_we);
    assign slow_be_n = ~sl_be;

    //------------------------------------------------------------------
    // Host answers
    //------------------------------------------------------------------
    // Each host bus answered independently, so DMA buses on different memories run concurrently
    assign h_ack = ack_sram | ack_sdram | ack_slow;
    assign h_err = err_ff;

    // Read data from the memory that answered
    always_comb
    begin
        for (int i = 0; i < NH; i++)
        begin
            if (ack_sram[i])
                h_rdata[i] = rd_sram;
            else if (ack_sdram[i])
                h_rdata[i] = rd_sdram;
            else
                h_rdata[i] = rd_slow;
        end
    end

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_mpu_burst_width: assert property ((h_req[H_MPU] && h_len[H_MPU] != '0 && h_size[H_MPU] == SZ_16
        && !h_err[H_MPU]) |=> h_err[H_MPU] && !h_ack[H_MPU])
        else $error("16-bit MPU burst not refused");
    a_lcd_burst_ok: assert property ((h_req[H_DMA0 + 1] && dma_lcd[1] && h_size[H_DMA0 + 1] == SZ_16
        && tgt_sram[H_DMA0 + 1] && !h_addr[H_DMA0 + 1][0]) |=> !h_err[H_DMA0 + 1])
        else $error("display channel 16-bit burst refused");
    a_sram_size_limit: assert property ((h_req[H_DMA0 + 3] && h_addr[H_DMA0 + 3] == SRAM_END
        && !h_err[H_DMA0 + 3]) |=> h_err[H_DMA0 + 3])
        else $error("access beyond internal SRAM not refused");
    a_lbus_reach_sdram: assert property (($rose(h_req[H_LBUS]) && legal[H_LBUS] && tgt_sdram[H_LBUS]
        && h_len[H_LBUS] == '0) |-> ##[1:1000] h_ack[H_LBUS])
        else $error("local bus access to SDRAM not answered");
    a_dsp_own_port: assert property (h_ack[H_DSP] |-> $past(h_req[H_DSP], 1)
        && !(h_ack[H_MPU] && !$past(h_req[H_MPU], 1)))
        else $error("DSP answer without DSP request");
    a_slow_cs_decode: assert property ((slow_cs_n != 4'hF) |-> $onehot(~slow_cs_n)
        && (slow_oe_n != slow_we_n) && (!$past(sl_en, 1) || sl_m_addr[27:26] == $past(sl_m_addr[27:26], 1)))
        else $error("slow chip select not one-hot or strobes wrong");

    c_dma_concurrent: cover property (h_ack[H_DMA0] && h_ack[H_DMA0 + 1]);
    c_host_error: cover property (h_err[H_DSP]);
    c_slow_read: cover property (!slow_oe_n ##1 slow_oe_n);

endmodule : memory_traffic_router

// File: rtl/mtr_mem_port.sv
//----------------------------------------------------------------------
// Memory interface port with arbitration and size adaptation
//----------------------------------------------------------------------
// Purpose: Arbitrates hosts onto one memory and sequences each beat
// Assumes: Requests are already decoded and legal for this memory
// Notes: A 32-bit access on a 16-bit memory takes two pieces
`timescale 1ns/1ps
module mtr_mem_port
    import mtr_pkg::*;
#(
    parameter int DW = 32,
    parameter int WAIT = 0
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [NH-1:0] req,
    input wire logic [NH-1:0] we,
    input wire logic [NH-1:0][1:0] size,
    input wire logic [NH-1:0][LEN_W-1:0] len,
    input wire logic [NH-1:0][31:0] addr,
    input wire logic [NH-1:0][31:0] wdata,
    output logic [NH-1:0] ack,
    output logic [31:0] rdata,
    output logic m_en,
    output logic m_we,
    output logic [31:0] m_addr,
    output logic [DW/8-1:0] m_be,
    output logic [DW-1:0] m_wdata,
    input wire logic [DW-1:0] m_rdata
);

    typedef enum logic [1:0] {ST_IDLE, ST_ACC, ST_GAP} mtr_port_st_t;
    localparam logic [3:0] WAIT_CNT = 4'(WAIT);

    mtr_port_st_t state_ff;
    logic [2:0] rr_ff, gnt_ff, pick, sel;
    logic found, go, last_cyc, ld_p1, fin, hold_ff, piece_ff, two_ff, we_ff;
    logic [3:0] cnt_ff, en_run_ff;
    logic [LEN_W-1:0] beat_ff, len_ff;
    logic [1:0] size_ff, src_s;
    logic [31:0] addr_ff, wd_ff, rbuf_ff, beat_addr, src_a, src_w, be_t, wd_t, raw, sh, rd;
    logic [NH-1:0] ack_ff;
    logic [31:0] rdata_ff, m_addr_ff;
    logic m_en_ff, m_we_ff;
    logic [DW/8-1:0] m_be_ff;
    logic [DW-1:0] m_wdata_ff;

    //------------------------------------------------------------------
    // Arbitration
    //------------------------------------------------------------------
    // Round robin search starting after the last served host
    always_comb
    begin
        pick = rr_ff;
        found = 1'b0;
        for (int i = 1; i <= NH; i++)
        begin
            if (!found && req[(int'(rr_ff) + i) % NH])
            begin
                found = 1'b1;
                pick = 3'((int'(rr_ff) + i) % NH);
            end
        end
    end

    // A held grant locks out every other host until its burst ends
    assign sel = hold_ff ? gnt_ff : pick;
    assign go = (state_ff == ST_IDLE) && (hold_ff ? req[gnt_ff] : found);
    assign beat_addr = addr[sel] + (32'(beat_ff) << size[sel]);
    assign last_cyc = (state_ff == ST_ACC) && (cnt_ff == 4'h0);
    assign ld_p1 = last_cyc && two_ff && !piece_ff;
    assign fin = last_cyc && !ld_p1;

    //------------------------------------------------------------------
    // Size adaptation
    //------------------------------------------------------------------
    // Lane steering of the piece about to start
    always_comb
    begin
        src_a = go ? beat_addr : addr_ff;
        src_s = go ? size[sel] : size_ff;
        src_w = go ? wdata[sel] : wd_ff;
        be_t = 32'h0000_0000;
        wd_t = 32'h0000_0000;
        if (DW == 32)
        begin
            case (src_s)
                SZ_8: be_t = 32'h0000_0001 << src_a[1:0];
                SZ_16: be_t = 32'h0000_0003 << src_a[1:0];
                default: be_t = 32'h0000_000F;
            endcase
            case (src_s)
                SZ_8: wd_t = {4{src_w[7:0]}};
                SZ_16: wd_t = {2{src_w[15:0]}};
                default: wd_t = src_w;
            endcase
        end
        else
        begin
            be_t = (src_s == SZ_8) ? (32'h0000_0001 << src_a[0]) : 32'h0000_0003;
            case (src_s)
                SZ_8: wd_t = {16'h0000, {2{src_w[7:0]}}};
                SZ_16: wd_t = {16'h0000, src_w[15:0]};
                default: wd_t = {16'h0000, ld_p1 ? src_w[31:16] : src_w[15:0]};
            endcase
        end
    end

    // Read data right-justified for the host
    always_comb
    begin
        raw = 32'(m_rdata);
        sh = (DW == 32) ? (raw >> {addr_ff[1:0], 3'h0}) : (raw >> {addr_ff[0], 3'h0});
        case (size_ff)
            SZ_8: rd = {24'h00_0000, sh[7:0]};
            SZ_16: rd = {16'h0000, sh[15:0]};
            default: rd = (DW == 32) ? raw : {raw[15:0], rbuf_ff[15:0]};
        endcase
    end

    //------------------------------------------------------------------
    // Sequencing
    //------------------------------------------------------------------
    // Beat state machine
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            state_ff <= ST_IDLE;
        else
            case (state_ff)
                ST_IDLE: if (go) state_ff <= ST_ACC;
                ST_ACC: if (fin) state_ff <= ST_GAP;
                ST_GAP: state_ff <= ST_IDLE;
                default: state_ff <= ST_IDLE;
            endcase
    end

    // Latched access and wait state count
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            gnt_ff <= 3'h0;
            size_ff <= SZ_8;
            we_ff <= 1'b0;
            addr_ff <= 32'h0000_0000;
            wd_ff <= 32'h0000_0000;
            piece_ff <= 1'b0;
            two_ff <= 1'b0;
            cnt_ff <= 4'h0;
            rbuf_ff <= 32'h0000_0000;
        end
        else if (go)
        begin
            gnt_ff <= sel;
            size_ff <= size[sel];
            we_ff <= we[sel];
            addr_ff <= beat_addr;
            wd_ff <= wdata[sel];
            piece_ff <= 1'b0;
            two_ff <= (DW == 16) && (size[sel] == SZ_32);
            cnt_ff <= WAIT_CNT;
        end
        else if (ld_p1)
        begin
            piece_ff <= 1'b1;
            cnt_ff <= WAIT_CNT;
            rbuf_ff <= raw;
        end
        else if (state_ff == ST_ACC && cnt_ff != 4'h0)
            cnt_ff <= cnt_ff - 4'h1;
    end

    // Memory strobes held for the whole wait window
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            m_en_ff <= 1'b0;
            m_we_ff <= 1'b0;
            m_addr_ff <= 32'h0000_0000;
            m_be_ff <= '0;
            m_wdata_ff <= '0;
        end
        else if (go || ld_p1)
        begin
            m_en_ff <= 1'b1;
            m_we_ff <= go ? we[sel] : we_ff;
            m_addr_ff <= {src_a[31:2], ld_p1 ? 2'h2 : src_a[1:0]};
            m_be_ff <= be_t[DW/8-1:0];
            m_wdata_ff <= wd_t[DW-1:0];
        end
        else if (fin)
            m_en_ff <= 1'b0;
    end

    // Answer and burst progress
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            ack_ff <= '0;
            rdata_ff <= 32'h0000_0000;
            beat_ff <= '0;
            len_ff <= '0;
            hold_ff <= 1'b0;
            rr_ff <= 3'(NH - 1);
        end
        else
        begin
            ack_ff <= '0;
            if (go && !hold_ff)
                len_ff <= len[sel];
            if (fin)
            begin
                ack_ff[gnt_ff] <= 1'b1;
                rdata_ff <= rd;
                if (beat_ff == len_ff)
                begin
                    beat_ff <= '0;
                    hold_ff <= 1'b0;
                    rr_ff <= gnt_ff;
                end
                else
                begin
                    beat_ff <= beat_ff + 1'b1;
                    hold_ff <= 1'b1;
                end
            end
        end
    end

    assign ack = ack_ff;
    assign rdata = rdata_ff;
    assign m_en = m_en_ff;
    assign m_we = m_we_ff;
    assign m_addr = m_addr_ff;
    assign m_be = m_be_ff;
    assign m_wdata = m_wdata_ff;

    //------------------------------------------------------------------
    // Checks
    //------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Cycles since the current piece started
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            en_run_ff <= 4'h0;
        else if (go || ld_p1)
            en_run_ff <= 4'h0;
        else if (state_ff == ST_ACC)
            en_run_ff <= en_run_ff + 4'h1;
    end

    a_wait_state_len: assert property (last_cyc |-> m_en && en_run_ff == WAIT_CNT)
        else $error("piece ended after wrong wait count");
    a_grant_hold_burst: assert property (hold_ff |=> $stable(gnt_ff) && $onehot0(ack_ff))
        else $error("grant moved during burst");
    a_byte_lane_single: assert property ((m_en && size_ff == SZ_8) |-> $countones(m_be) == 1)
        else $error("byte access enabled more than one lane");

    c_two_piece: cover property (ld_p1);
    c_burst_beat: cover property (hold_ff && go);

endmodule : mtr_mem_port

// File: rtl/mtr_pkg.sv
//----------------------------------------------------------------------
// Memory traffic router package
//----------------------------------------------------------------------
// Purpose: Shared constants for the memory traffic router
// Assumes: 20 MHz core clock, seven host buses
// Notes: Host data is right-justified on every host bus
package mtr_pkg;

    // Host numbering
    localparam int NH = 7;
    localparam int H_MPU = 0;
    localparam int H_DSP = 1;
    localparam int H_DMA0 = 2;
    localparam int NDMA = 4;
    localparam int H_LBUS = 6;

    // Access size codes
    localparam logic [1:0] SZ_8 = 2'h0;
    localparam logic [1:0] SZ_16 = 2'h1;
    localparam logic [1:0] SZ_32 = 2'h2;
    localparam int LEN_W = 4;

    // Address decode
    localparam logic [3:0] SLOW_TAG = 4'h0;
    localparam int SLOW_HOLE_BIT = 25;
    localparam logic [5:0] SDRAM_TAG = 6'h04;
    localparam logic [31:0] SRAM_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_BYTES = 32'h0003_0000;
    localparam logic [31:0] SRAM_END = SRAM_BASE + SRAM_BYTES;

    // Memory data widths
    localparam int SRAM_DW = 32;
    localparam int SDRAM_DW = 16;
    localparam int SLOW_DW = 16;

    // Access times and derived wait states
    localparam int CLK_PERIOD_NS = 50;
    localparam int SRAM_ACCESS_NS = 50;
    localparam int SDRAM_ACCESS_NS = 100;
    localparam int SLOW_ACCESS_NS = 200;
    localparam int SRAM_WAIT = (SRAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1;
    localparam int SDRAM_WAIT = (SDRAM_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1;
    localparam int SLOW_WAIT = (SLOW_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS - 1;

endpackage : mtr_pkg

// File: testbench/mtr_mem_model.sv
//----------------------------------------------------------------------
// Memory model
//----------------------------------------------------------------------
// Purpose: Behavioural SRAM, SDRAM and slow memories
// Assumes: Strobes and byte enables as the router drives them
// Notes: Unselected read buses show a pattern that flips every cycle
`timescale 1ns/1ps
module mtr_mem_model
(
    input wire logic core_clk,
    input wire logic sram_en,
    input wire logic sram_we,
    input wire logic [15:0] sram_addr,
    input wire logic [3:0] sram_be,
    input wire logic [31:0] sram_wdata,
    output logic [31:0] sram_rdata,
    input wire logic sdram_cs_n,
    input wire logic sdram_oe_n,
    input wire logic sdram_we_n,
    input wire logic [24:0] sdram_addr,
    input wire logic [1:0] sdram_be_n,
    input wire logic [15:0] sdram_wdata,
    output logic [15:0] sdram_rdata,
    input wire logic [3:0] slow_cs_n,
    input wire logic slow_oe_n,
    input wire logic slow_we_n,
    input wire logic [23:0] slow_addr,
    input wire logic [1:0] slow_be_n,
    input wire logic [15:0] slow_wdata,
    output logic [15:0] slow_rdata
);
    logic [7:0] sm [int];
    logic [7:0] xm [int];
    logic [15:0] junk_ff = 16'hA5C3;
    // Store bytes while write strobes stand
    always @(posedge core_clk)
    begin
        junk_ff <= ~junk_ff;
        for (int b = 0; b < 4; b++)
        begin
            if (sram_en && sram_we && sram_be[b])
                sm[{sram_addr, b[1:0]}] = sram_wdata[8*b+:8];
            if (b < 2 && !sdram_cs_n && !sdram_we_n && !sdram_be_n[b])
                xm[{2'h2, sdram_addr, b[0]}] = sdram_wdata[8*b+:8];
            if (b < 2 && !slow_we_n && !slow_be_n[b])
                xm[{2'h1, slow_cs_n, slow_addr, b[0]}] = slow_wdata[8*b+:8];
        end
    end
    // Read data only while selected for reading
    always @*
    begin
        sram_rdata = {junk_ff, ~junk_ff};
        sdram_rdata = junk_ff;
        slow_rdata = ~junk_ff;
        for (int b = 0; b < 4; b++)
        begin
            if (sram_en && !sram_we)
                sram_rdata[8*b+:8] = sm[{sram_addr, b[1:0]}];
            if (b < 2 && !sdram_cs_n && !sdram_oe_n)
                sdram_rdata[8*b+:8] = xm[{2'h2, sdram_addr, b[0]}];
            if (b < 2 && !slow_oe_n && slow_cs_n != 4'hF)
                slow_rdata[8*b+:8] = xm[{2'h1, slow_cs_n, slow_addr, b[0]}];
        end
    end
endmodule : mtr_mem_model

// File: testbench/testbench.sv
//----------------------------------------------------------------------
// Router testbench
//----------------------------------------------------------------------
// Purpose: Random and corner accesses from all seven host buses
// Assumes: Inputs change at the falling edge
// Notes: Latencies compared as differences between memories
`timescale 1ns/1ps
module testbench
    import mtr_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [NH-1:0] h_req = '0, h_we = '0, h_ack, h_err;
    logic [NH-1:0][1:0] h_size = '0;
    logic [NH-1:0][LEN_W-1:0] h_len = '0;
    logic [NH-1:0][31:0] h_addr = '0, h_wdata = '0, h_rdata;
    logic [NDMA-1:0] dma_lcd = '0;
    logic sram_en, sram_we, sdram_cs_n, sdram_oe_n, sdram_we_n, slow_oe_n, slow_we_n;
    logic [15:0] sram_addr, sdram_wdata, sdram_rdata, slow_wdata, slow_rdata;
    logic [3:0] sram_be, slow_cs_n, seen_cs;
    logic [31:0] sram_wdata, sram_rdata, a, v, w, rd;
    logic [24:0] sdram_addr;
    logic [23:0] slow_addr;
    logic [1:0] sdram_be_n, slow_be_n;
    logic er;
    int n_mismatch = 0, checks = 0, t, t0, t1, t2;
    memory_traffic_router i_memory_traffic_router (.*);
    mtr_mem_model i_mtr_mem_model (.*);
    // Clock
    always #25 core_clk = ~core_clk;
    // Chip select seen while slow strobes stand
    always @(negedge core_clk)
        if (!slow_oe_n || !slow_we_n)
            seen_cs = slow_cs_n;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    function automatic logic [31:0] lane(input logic [31:0] x, input logic [1:0] sz, input int off);
        logic [31:0] s;
        s = x >> (8 * off);
        return sz == SZ_8 ? {24'h0, s[7:0]} : sz == SZ_16 ? {16'h0, s[15:0]} : x;
    endfunction : lane
    function automatic logic [31:0] where(input int r);
        logic [31:0] o;
        o = $urandom & 32'h0000_FFFC;
        return r == 0 ? SRAM_BASE + o : r == 1 ? 32'h1000_0000 + o : 32'h0800_0000 + o;
    endfunction : where
    // One host access, beat data counts up from wd
    task automatic xfer(input int h, input logic wr, input logic [1:0] sz, input logic [3:0] ln,
        input logic [31:0] ad, input logic [31:0] wd, output logic [31:0] r, output logic e, output int c);
        int n;
        n = 0;
        e = 0;
        c = 0;
        @(negedge core_clk);
        h_we[h] = wr;
        h_size[h] = sz;
        h_len[h] = ln;
        h_addr[h] = ad;
        h_wdata[h] = wd;
        h_req[h] = 1'b1;
        while (n <= ln && !e && c < 200)
        begin
            @(negedge core_clk);
            c++;
            if (h_ack[h] === 1'b1)
            begin
                r = h_rdata[h];
                n++;
                h_wdata[h] = wd + n;
            end
            e = h_err[h] === 1'b1;
        end
        h_req[h] = 1'b0;
        chk(c < 200, 1);
    endtask : xfer
    // Write then read back, or expect refusal
    task automatic try(input int h, input logic [1:0] sz, input logic [3:0] ln,
        input logic [31:0] ad, input logic ex);
        logic [31:0] x, r;
        logic e;
        int c;
        x = $urandom & 32'h0000_7FF0;
        xfer(h, 1, sz, ln, ad, x, r, e, c);
        chk(e, ex);
        if (!ex)
        begin
            xfer(h, 0, sz, ln, ad, 0, r, e, c);
            chk(r, x + ln);
        end
    endtask : try
    // Watchdog
    initial
    begin
        #(50 * 20000);
        n_mismatch++;
        summarize;
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'he72d));
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        chk({h_ack, h_err, sram_en, sdram_cs_n, slow_cs_n}, 32'h0000_001F);
        rst = 1'b0;
        // Every host to every memory; host 6 alone on the local bus
        for (int i = 0; i < 21; i++)
        begin
            a = where(i % 3);
            v = $urandom;
            w = $urandom;
            xfer(i % 7, 1, SZ_32, 0, a, v, rd, er, t);
            xfer(i % 7, 0, SZ_32, 0, a, 0, rd, er, t);
            chk(rd, v);
            xfer((i + 3) % 7, 0, SZ_16, 0, a + 2, 0, rd, er, t);
            chk(rd, lane(v, SZ_16, 2));
            xfer((i + 5) % 7, 0, SZ_8, 0, a + i % 4, 0, rd, er, t);
            chk(rd, lane(v, SZ_8, i % 4));
            xfer((i + 1) % 7, 1, SZ_8, 0, a + i % 4, w, rd, er, t);
            v[8*(i%4)+:8] = w[7:0];
            xfer(i % 7, 0, SZ_32, 0, a, 0, rd, er, t);
            chk(rd, v);
        end
        chk(seen_cs, 4'b1011);
        // Wait states per memory, single then in parallel
        xfer(0, 1, SZ_32, 0, where(0), 0, rd, er, t0);
        xfer(0, 1, SZ_32, 0, where(1), 0, rd, er, t1);
        xfer(0, 1, SZ_32, 0, where(2), 0, rd, er, t2);
        chk(t1 - t0, 2 * SDRAM_WAIT + 1 - SRAM_WAIT);
        chk(t2 - t0, 2 * SLOW_WAIT + 1 - SRAM_WAIT);
        fork
            xfer(H_DMA0, 1, SZ_32, 0, where(0), 0, v, er, t0);
            xfer(H_DMA0 + 1, 1, SZ_32, 0, where(1), 0, w, er, t1);
            xfer(H_DMA0 + 2, 1, SZ_32, 0, where(2), 0, a, er, t2);
        join
        chk(t2 - t0, 2 * SLOW_WAIT + 1 - SRAM_WAIT);
        // Burst widths, alignment and map corners
        dma_lcd = 4'b0010;
        try(H_MPU, SZ_16, 1, SRAM_BASE, 1);
        try(H_DSP, SZ_8, 1, SRAM_BASE, 1);
        try(H_LBUS, SZ_32, 3, SRAM_BASE + 32'h0000_0100, 0);
        try(H_DMA0, SZ_16, 3, SRAM_BASE, 1);
        try(H_DMA0 + 1, SZ_16, 3, SRAM_BASE + 32'h0000_0200, 0);
        try(H_DMA0 + 2, SZ_16, 0, SRAM_BASE + 32'h0000_0001, 1);
        try(H_DSP, SZ_32, 0, 32'h1000_0002, 1);
        try(H_MPU, 2'h3, 0, SRAM_BASE, 1);
        try(H_DMA0 + 3, SZ_32, 0, SRAM_END, 1);
        try(H_DMA0 + 3, SZ_32, 0, SRAM_END - 4, 0);
        // Two bursts racing for the internal memory
        fork
            try(H_DMA0 + 3, SZ_32, 7, SRAM_BASE + 32'h0000_0400, 0);
            try(H_MPU, SZ_32, 7, SRAM_BASE + 32'h0000_0800, 0);
        join
        summarize;
    end
endmodule : testbench
